// file: rcap_pkg.sv
package rcap_pkg;

  // ************************************************************
  // bus map
  // ************************************************************
  localparam int APB_AW = 12;
  localparam logic [11:0] OFS_CAP_LO = 12'h008;
  localparam logic [11:0] OFS_CAP_HI = 12'h00c;
  localparam logic [11:0] OFS_CTRL = 12'h020;
  localparam logic [11:0] OFS_STAT = 12'h024;

  // ************************************************************
  // capability field positions
  // ************************************************************
  localparam int MASK_LSB = 48;
  localparam int NFR_LSB = 40;
  localparam int PSI_BIT = 39;
  localparam int SPS_LSB = 34;
  localparam int FRO_LSB = 24;
  localparam int ISO_BIT = 23;
  localparam int ZLR_BIT = 22;
  localparam int MAX_GUEST_WIDTH_LSB = 16;
  localparam int SUPPORTED_ADJUSTED_WIDTHS_LSB = 8;
  localparam int CM_BIT = 7;

  // ************************************************************
  // capability field values
  // ************************************************************
  localparam logic [5:0] MAX_MASK_VAL = 6'h09;
  localparam logic [7:0] NFR_VAL = 8'h00;
  localparam logic PSI_VAL = 1'b1;
  localparam logic [3:0] SPS_VAL = 4'h0;
  localparam logic [9:0] FRO_VAL = 10'h020;
  localparam logic ISO_VAL = 1'b1;
  localparam logic ZLR_VAL = 1'b1;
  localparam logic [5:0] MAX_GUEST_WIDTH_VAL = 6'h23;
  localparam logic [4:0] SUPPORTED_ADJUSTED_WIDTHS_VAL = 5'h02;
  localparam logic CM_VAL = 1'b0;
  // first fault record sits at base plus sixteen times the offset
  localparam logic [13:0] FRO_BYTES = {FRO_VAL, 4'h0};

  localparam logic [63:0] CAP_VALUE =
    (64'(MAX_MASK_VAL) << MASK_LSB) |
    (64'(NFR_VAL) << NFR_LSB) |
    (64'(PSI_VAL) << PSI_BIT) |
    (64'(SPS_VAL) << SPS_LSB) |
    (64'(FRO_VAL) << FRO_LSB) |
    (64'(ISO_VAL) << ISO_BIT) |
    (64'(ZLR_VAL) << ZLR_BIT) |
    (64'(MAX_GUEST_WIDTH_VAL) << MAX_GUEST_WIDTH_LSB) |
    (64'(SUPPORTED_ADJUSTED_WIDTHS_VAL) << SUPPORTED_ADJUSTED_WIDTHS_LSB) |
    (64'(CM_VAL) << CM_BIT);

  // ************************************************************
  // adjusted widths, control and status
  // ************************************************************
  localparam int ADJUSTED_GUEST_WIDTH_N = 5;
  localparam logic [6:0] ADJUSTED_GUEST_WIDTH_W0 = 7'h1e;
  localparam logic [6:0] ADJUSTED_GUEST_WIDTH_W1 = 7'h27;
  localparam logic [6:0] ADJUSTED_GUEST_WIDTH_W2 = 7'h30;
  localparam logic [6:0] ADJUSTED_GUEST_WIDTH_W3 = 7'h39;
  localparam logic [6:0] ADJUSTED_GUEST_WIDTH_W4 = 7'h40;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_CLR_BIT = 1;
  localparam logic CTRL_EN_RST = 1'b1;
  localparam int CNT_W = 16;
  localparam int STAT_LAST_BIT = 16;

endpackage

// file: rcap_addr_chk.sv
`timescale 1ns/1ps
module rcap_addr_chk
  import rcap_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // control
  input wire logic adjusted_guest_width_en_i,
  // request
  input wire logic req_valid_i,
  input wire logic [63:0] req_addr_i,
  input wire logic [2:0] req_adjusted_guest_width_i,
  // result
  output logic rsp_valid_o,
  output logic rsp_block_o,
  output logic [6:0] rsp_width_o
);

  typedef struct packed {
    logic valid;
    logic block;
    logic [6:0] width;
  } rcap_chk_t;

  rcap_chk_t s_r;
  rcap_chk_t s_nxt;

  function automatic logic [6:0] adjusted_guest_width_width(input logic [2:0] idx);
    case (idx)
      3'h0: adjusted_guest_width_width = ADJUSTED_GUEST_WIDTH_W0;
      3'h1: adjusted_guest_width_width = ADJUSTED_GUEST_WIDTH_W1;
      3'h2: adjusted_guest_width_width = ADJUSTED_GUEST_WIDTH_W2;
      3'h3: adjusted_guest_width_width = ADJUSTED_GUEST_WIDTH_W3;
      default: adjusted_guest_width_width = ADJUSTED_GUEST_WIDTH_W4;
    endcase
  endfunction

  function automatic logic above(input logic [63:0] a,
                                 input logic [6:0] w);
    above = |(a >> w);
  endfunction

  logic [6:0] max_guest_width_w;
  logic [6:0] adjusted_guest_width_w;
  logic [6:0] eff_w;
  logic adjusted_guest_width_ok;

  always_comb
  begin
    max_guest_width_w = 7'({1'b0, MAX_GUEST_WIDTH_VAL}) + 7'h01;
    adjusted_guest_width_w = adjusted_guest_width_width(req_adjusted_guest_width_i);
    // unadvertised widths are refused, not guessed
    adjusted_guest_width_ok = (req_adjusted_guest_width_i < 3'(ADJUSTED_GUEST_WIDTH_N)) && SUPPORTED_ADJUSTED_WIDTHS_VAL[req_adjusted_guest_width_i];
    eff_w = (adjusted_guest_width_w < max_guest_width_w) ? adjusted_guest_width_w : max_guest_width_w;
    s_nxt = s_r;
    s_nxt.valid = req_valid_i;
    if (req_valid_i)
    begin
      if (adjusted_guest_width_en_i)
      begin
        s_nxt.block = above(req_addr_i, eff_w) | ~adjusted_guest_width_ok;
        s_nxt.width = eff_w;
      end
      else
      begin
        s_nxt.block = above(req_addr_i, max_guest_width_w);
        s_nxt.width = max_guest_width_w;
      end
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign rsp_valid_o = s_r.valid;
  assign rsp_block_o = s_r.block;
  assign rsp_width_o = s_r.width;

endmodule

// file: rcap_top.sv
// Design decisions made here: the APB slave port and the register offsets.
`timescale 1ns/1ps
module rcap_top
  import rcap_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [APB_AW-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic pready_o,
  output logic [31:0] prdata_o,
  output logic pslverr_o,
  // remap address check
  input wire logic chk_valid_i,
  input wire logic [63:0] chk_addr_i,
  input wire logic [2:0] chk_adjusted_guest_width_i,
  output logic chk_done_o,
  output logic chk_block_o,
  output logic [6:0] chk_width_o
);

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [31:0] rdata;
    logic slverr;
    logic adjusted_guest_width_en;
    logic [CNT_W-1:0] blk_cnt;
    logic last_block;
  } rcap_state_t;

  rcap_state_t s_r;
  rcap_state_t s_nxt;

  logic rsp_valid;
  logic rsp_block;
  logic [6:0] rsp_width;

  // ************************************************************
  // decode helpers
  // ************************************************************
  function automatic logic is_map(input logic [APB_AW-1:0] a);
    is_map = (a == OFS_CAP_LO) || (a == OFS_CAP_HI) ||
             (a == OFS_CTRL) || (a == OFS_STAT);
  endfunction

  function automatic logic [31:0] cap_word(input logic hi);
    cap_word = hi ? CAP_VALUE[63:32] : CAP_VALUE[31:0];
  endfunction

  // ************************************************************
  // capability fields
  // ************************************************************
  // count minus one field
  logic [7:0] nfr_f;
  // eight bits cap it at 256
  logic [8:0] nfr_total;
  logic psi_f;
  logic [3:0] sps_f;
  logic [9:0] fro_f;
  logic iso_f;
  logic zlr_f;
  logic [5:0] max_guest_width_f;
  logic [4:0] supported_adjusted_widths_f;
  logic cm_f;
  logic [5:0] mask_f;

  assign nfr_f = CAP_VALUE[NFR_LSB +: 8];
  assign nfr_total = 9'({1'b0, nfr_f}) + 9'h001;
  assign psi_f = CAP_VALUE[PSI_BIT];
  assign sps_f = CAP_VALUE[SPS_LSB +: 4];
  assign fro_f = CAP_VALUE[FRO_LSB +: 10];
  assign iso_f = CAP_VALUE[ISO_BIT];
  assign zlr_f = CAP_VALUE[ZLR_BIT];
  assign max_guest_width_f = CAP_VALUE[MAX_GUEST_WIDTH_LSB +: 6];
  assign supported_adjusted_widths_f = CAP_VALUE[SUPPORTED_ADJUSTED_WIDTHS_LSB +: 5];
  assign cm_f = CAP_VALUE[CM_BIT];
  assign mask_f = CAP_VALUE[MASK_LSB +: 6];

  // ************************************************************
  // address check
  // ************************************************************
  // checker enforces max width
  rcap_addr_chk u_chk (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .adjusted_guest_width_en_i(s_r.adjusted_guest_width_en),
    .req_valid_i(chk_valid_i),
    .req_addr_i(chk_addr_i),
    .req_adjusted_guest_width_i(chk_adjusted_guest_width_i),
    .rsp_valid_o(rsp_valid),
    .rsp_block_o(rsp_block),
    .rsp_width_o(rsp_width)
  );

  // ************************************************************
  // register file
  // ************************************************************
  logic setup;
  logic access;
  logic wr_ctrl;
  logic clr_cnt;

  always_comb
  begin
    setup = psel_i & ~penable_i;
    access = psel_i & penable_i;
    wr_ctrl = access & pwrite_i & (paddr_i == OFS_CTRL) & pstrb_i[0];
    clr_cnt = wr_ctrl & pwdata_i[CTRL_CLR_BIT];
    s_nxt = s_r;
    // read data latched in setup, so prdata leaves a flop
    if (setup)
    begin
      s_nxt.slverr = ~is_map(paddr_i);
      s_nxt.rdata = 32'h0000_0000;
      if (!pwrite_i)
      begin
        case (paddr_i)
          OFS_CAP_LO: s_nxt.rdata = cap_word(1'b0);
          OFS_CAP_HI: s_nxt.rdata = cap_word(1'b1);
          OFS_CTRL:
            s_nxt.rdata[CTRL_EN_BIT] = s_r.adjusted_guest_width_en;
          OFS_STAT:
          begin
            s_nxt.rdata[CNT_W-1:0] = s_r.blk_cnt;
            s_nxt.rdata[STAT_LAST_BIT] = s_r.last_block;
          end
          default: s_nxt.rdata = 32'h0000_0000;
        endcase
      end
    end
    if (wr_ctrl)
      s_nxt.adjusted_guest_width_en = pwdata_i[CTRL_EN_BIT];
    if (clr_cnt)
      s_nxt.blk_cnt = '0;
    // a block in the clear cycle still counts
    if (rsp_valid)
    begin
      s_nxt.last_block = rsp_block;
      if (rsp_block && (s_nxt.blk_cnt != '1))
        s_nxt.blk_cnt = s_nxt.blk_cnt + CNT_W'(1);
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      s_r <= '0;
      s_r.adjusted_guest_width_en <= CTRL_EN_RST;
    end
    else
      s_r <= s_nxt;
  end

  // ************************************************************
  // outputs
  // ************************************************************
  // one wait-free access phase
  assign pready_o = psel_i & penable_i;
  assign prdata_o = s_r.rdata;
  assign pslverr_o = s_r.slverr & psel_i & penable_i;
  assign chk_done_o = rsp_valid;
  assign chk_block_o = rsp_block;
  assign chk_width_o = rsp_width;

endmodule

// file: rcap_props.sv
`timescale 1ns/1ps
module rcap_props
  import rcap_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // apb
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [APB_AW-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  input wire logic pready_o,
  input wire logic [31:0] prdata_o,
  input wire logic pslverr_o,
  // address check
  input wire logic chk_valid_i,
  input wire logic [63:0] chk_addr_i,
  input wire logic [2:0] chk_adjusted_guest_width_i,
  input wire logic chk_done_o,
  input wire logic chk_block_o,
  input wire logic [6:0] chk_width_o
);
  // ********
  // checks
  // ********
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  logic rd;
  logic hi_clr;
  logic [6:0] mw;
  assign rd = psel_i && !penable_i && !pwrite_i;
  assign mw = 7'(MAX_GUEST_WIDTH_VAL) + 7'h01;
  assign hi_clr = (chk_addr_i >> mw) == 64'h0;
  a_ready_access:
    assert property (psel_i && penable_i |-> pready_o) else $error("no ready");
  a_cap_low:
    assert property (rd && paddr_i == OFS_CAP_LO |=> prdata_o == CAP_VALUE[31:0])
    else $error("low word");
  a_cap_high:
    assert property (rd && paddr_i == OFS_CAP_HI |=> prdata_o == CAP_VALUE[63:32])
    else $error("high word");
  a_cap_no_err:
    assert property (psel_i && penable_i && paddr_i[11:3] == 9'h001
      |-> !pslverr_o) else $error("cap error");
  a_done_pulse:
    assert property (chk_valid_i |=> chk_done_o) else $error("no done");
  a_done_cause:
    assert property (!chk_valid_i |=> !chk_done_o) else $error("stray done");
  a_high_block:
    assert property (chk_valid_i && !hi_clr |=> chk_block_o) else $error("not blocked");
  a_low_pass:
    assert property (chk_valid_i && chk_adjusted_guest_width_i == 3'h1 && hi_clr
      |=> !chk_block_o && chk_width_o == $past(mw)) else $error("bad pass");
  a_block_hold:
    assert property (!chk_valid_i |=> $stable(chk_block_o)) else $error("no hold");
  cp_cap_read: cover property (rd && paddr_i == OFS_CAP_HI);
  cp_blocked: cover property (chk_done_o && chk_block_o);
  cp_passed: cover property (chk_done_o && !chk_block_o);
endmodule

// file: test_dma_remap_capability_fields.sv
`timescale 1ns/1ps
module test_dma_remap_capability_fields;
  import rcap_pkg::*;
  logic sys_clk_i, rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
  logic chk_valid_i, chk_done_o, chk_block_o, adjusted_guest_width_en, last_blk;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o;
  logic [3:0] pstrb_i;
  logic [63:0] chk_addr_i;
  logic [2:0] chk_adjusted_guest_width_i;
  logic [6:0] chk_width_o;
  logic [6:0] agw [5] = '{ADJUSTED_GUEST_WIDTH_W0, ADJUSTED_GUEST_WIDTH_W1, ADJUSTED_GUEST_WIDTH_W2, ADJUSTED_GUEST_WIDTH_W3, ADJUSTED_GUEST_WIDTH_W4};
  logic [33:0] apb_q [$];
  logic [7:0] chk_q [$];
  logic [33:0] ae;
  logic [7:0] ce;
  int n_fail, n_checks, n_blk, seed;
  rcap_top dut_u (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .pready_o(pready_o),
    .prdata_o(prdata_o), .pslverr_o(pslverr_o), .chk_valid_i(chk_valid_i),
    .chk_addr_i(chk_addr_i), .chk_adjusted_guest_width_i(chk_adjusted_guest_width_i),
    .chk_done_o(chk_done_o), .chk_block_o(chk_block_o),
    .chk_width_o(chk_width_o));
  // ********
  // helpers
  // ********
  task check(input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // with adjusted widths enabled, an unsupported width index blocks; width is still the smaller one
  function logic [7:0] exp_chk(input logic [63:0] a, input logic [2:0] i);
    logic [6:0] w;
    logic [6:0] aw;
    logic bad;
    w = 7'(MAX_GUEST_WIDTH_VAL) + 7'h01;
    aw = (i > 3'h4) ? ADJUSTED_GUEST_WIDTH_W4 : agw[i];
    bad = adjusted_guest_width_en && (i > 3'h4 || !SUPPORTED_ADJUSTED_WIDTHS_VAL[i]);
    if (adjusted_guest_width_en && aw < w)
      w = aw;
    return {bad || (a >> w) != 64'h0, w};
  endfunction
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    input logic [32:0] e);
    @(posedge sys_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    apb_q.push_back({w, e});
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    @(posedge sys_clk_i);
    while (pready_o !== 1'b1)
      @(posedge sys_clk_i);
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task chk(input logic [63:0] a, input logic [2:0] i);
    logic [7:0] e;
    @(posedge sys_clk_i);
    chk_valid_i <= 1'b1;
    chk_addr_i <= a;
    chk_adjusted_guest_width_i <= i;
    e = exp_chk(a, i);
    chk_q.push_back(e);
    n_blk += e[7];
    last_blk = e[7];
  endtask
  // ********
  // monitor
  // ********
  always @(posedge sys_clk_i)
  begin
    if (psel_i && penable_i && pready_o === 1'b1 && apb_q.size() > 0)
    begin
      ae = apb_q.pop_front();
      check(pslverr_o, ae[32]);
      if (!ae[33])
        check(prdata_o, ae[31:0]);
    end
    if (chk_done_o === 1'b1 && chk_q.size() > 0)
    begin
      ce = chk_q.pop_front();
      check({chk_block_o, chk_width_o}, ce);
    end
  end
  initial
  begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end
  initial
  begin
    #20000;
    n_fail++;
    $display("wrong value at %0t: timeout", $time);
    conclude;
  end
  // ********
  // tests
  // ********
  initial
  begin
    seed = 32'h25718ef3;
    {rst_i, adjusted_guest_width_en} = 2'b11;
    {psel_i, penable_i, pwrite_i, chk_valid_i} = 4'h0;
    paddr_i = 12'h000;
    pwdata_i = 32'h0;
    pstrb_i = 4'hf;
    chk_addr_i = 64'h0;
    chk_adjusted_guest_width_i = 3'h0;
    repeat (10) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    // fixed words survive writes
    for (int i = 0; i < 2; i++)
    begin
      ae = {2'b00, i ? CAP_VALUE[63:32] : CAP_VALUE[31:0]};
      apb(1'b0, i ? OFS_CAP_HI : OFS_CAP_LO, 32'h0, ae[32:0]);
      apb(1'b1, i ? OFS_CAP_HI : OFS_CAP_LO, $random(seed), 33'h0);
      apb(1'b0, i ? OFS_CAP_HI : OFS_CAP_LO, 32'h0, ae[32:0]);
    end
    apb(1'b0, 12'h100, 32'h0, {1'b1, 32'h0});
    apb(1'b1, 12'h104, $random(seed), {1'b1, 32'h0});
    $display("test registers done");
    for (int k = 0; k < 2; k++)
    begin
      apb(1'b1, OFS_CTRL, {30'h0, 1'b1, !k[0]}, 33'h0);
      adjusted_guest_width_en = !k[0];
      n_blk = 0;
      apb(1'b0, OFS_CTRL, 32'h0, {32'h0, adjusted_guest_width_en});
      chk(64'h0000_000f_ffff_ffff, 3'h1);
      chk(64'h0000_0010_0000_0000, 3'h1);
      for (int i = 0; i < 40; i++)
        chk({$random(seed), $random(seed)} >> ($random(seed) & 63), i[2:0]);
      @(posedge sys_clk_i);
      chk_valid_i <= 1'b0;
      @(posedge sys_clk_i);
      apb(1'b0, OFS_STAT, 32'h0, {16'h0, last_blk, 16'(n_blk)});
      $display("test checks pass %0d done", k);
    end
    conclude;
  end
endmodule
bind rcap_top rcap_props chk_u (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
  .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
  .pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o),
  .chk_valid_i(chk_valid_i), .chk_addr_i(chk_addr_i),
  .chk_adjusted_guest_width_i(chk_adjusted_guest_width_i), .chk_done_o(chk_done_o),
  .chk_block_o(chk_block_o), .chk_width_o(chk_width_o));
